/* File: qsm_defs.svh */
// Constants for the quad-rate sample multiplexer
`ifndef QSM_DEFS_SVH
`define QSM_DEFS_SVH

`define QSM_CLK_HZ 125000000
`define QSM_PCM_W 24
`define QSM_FIFO_DEPTH 4
`define QSM_MEM_AW 7
`define QSM_PERIOD_W 12
`define QSM_PERIOD_SAT 12'hFFF

`define QSM_SLOTS_MADI64 7'h40
`define QSM_SLOTS_MADI56 7'h38
`define QSM_SLOTS_OPTICAL 7'h08

`define QSM_FS_NOM_HZ 48000
`define QSM_FS64_MAX_HZ 48480
`define QSM_VARI_PERMIL 125
`define QSM_FS56_MIN_HZ (`QSM_FS_NOM_HZ * (1000 - `QSM_VARI_PERMIL) / 1000)
`define QSM_FS56_MAX_HZ (`QSM_FS_NOM_HZ * (1000 + `QSM_VARI_PERMIL) / 1000)
`define QSM_PAYLOAD_MAX_BPS 100000000
`define QSM_SLOT_BITS 32

`define QSM_FS64_MIN_CYC \
	12'((`QSM_CLK_HZ + `QSM_FS64_MAX_HZ - 1) / `QSM_FS64_MAX_HZ)
`define QSM_FS56_MIN_CYC \
	12'((`QSM_CLK_HZ + `QSM_FS56_MAX_HZ - 1) / `QSM_FS56_MAX_HZ)
`define QSM_FS56_MAX_CYC 12'(`QSM_CLK_HZ / `QSM_FS56_MIN_HZ)
`define QSM_PAY_MIN_CYC(n) \
	12'((64'd125000000 * 64'(n) * 64'd32 + 64'd99999999) / 64'd100000000)

`endif

/* File: qsm_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module qsm_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Fill side
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	// Drain side
	output logic [WIDTH-1:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;

	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
		(wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign wr_ready_o = !full;
	assign rd_valid_o = !empty;
	assign rd_data_o = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			wr_ptr_r <= '0;
		end else if (wr_valid_i && !full) begin
			wr_ptr_r <= wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (wr_valid_i && !full) begin
			mem_r[wr_ptr_r[AW-1:0]] <= wr_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			rd_ptr_r <= '0;
		end else if (rd_ready_i && !empty) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

/* File: qsm_link_sink.sv */
// Far-side link receiver model: takes slot words promptly or with stalls
`timescale 1ns/1ps
module qsm_link_sink (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Link slot stream
	input wire logic link_valid_i,
	output logic link_ready_o,
	// Pacing choice of the bench
	input wire logic slow_i
);
	logic [1:0] pace_r;

	//////////////////////////////////////////////////////////////////////
	// Ready changes just after the edge; words are taken at most one slot a cycle
	always @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			pace_r <= 2'h0;
		end else if (link_valid_i) begin
			pace_r <= pace_r + 2'h1;
		end
		// Slow pacing stands in for a receiver tied to line rate
		link_ready_o <= #1 rstn_i && (!slow_i || pace_r != 2'h3);
	end
endmodule

/* File: qsm_mux.sv */
// Quad/double-rate sample interleaver onto single-rate link frames
`timescale 1ns/1ps
`include "qsm_defs.svh"
module qsm_mux (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Configuration, applied at frame start
	input wire qsm_pkg::qsm_cfg_t cfg_i,
	// Jitter-cleaned recovered frame clock
	input wire logic frame_sync_i,
	// High-rate samples, channel-major per high-rate period
	input wire qsm_pkg::qsm_in_t in_word_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	// Link slot stream
	output qsm_pkg::qsm_link_word_t link_word_o,
	output logic link_valid_o,
	input wire logic link_ready_i,
	output logic link_frame_o,
	// Status
	output logic [6:0] chan_count_o,
	output logic rate_err_o,
	output logic underrun_o
);
	import qsm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	qsm_cfg_t cfg_r;
	qsm_rd_state_t rd_state_r;
	logic [`QSM_PCM_W-1:0] mem_r [0:(1<<`QSM_MEM_AW)-1];
	qsm_in_t fifo_word;
	logic fifo_valid;
	logic fifo_ready;
	logic tick;
	logic frame_pend_r;
	logic start;
	logic flush;
	logic [6:0] slots;
	logic [1:0] shift;
	logic [6:0] n_ch;
	logic [1:0] last_ph;
	logic [5:0] wr_ch_r;
	logic [1:0] wr_ph_r;
	logic [7:0] wr_addr;
	logic wr_bank_r;
	logic wr_fire;
	logic wr_last;
	logic fill_done_r;
	logic rd_bank_r;
	logic mute_r;
	logic [6:0] rd_slot_r;
	logic [6:0] nx_slot;
	logic load;
	qsm_link_word_t link_word_r;
	logic underrun_r;
	logic [6:0] chan_count_r;

	////////////////////////////////////////////////////////////////////////
	// Input buffer and frame timing

	qsm_fifo #(
		.WIDTH($bits(qsm_in_t)),
		.DEPTH(`QSM_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.wr_data_i(in_word_i),
		.wr_valid_i(in_valid_i),
		.wr_ready_o(in_ready_o),
		.rd_data_o(fifo_word),
		.rd_valid_o(fifo_valid),
		.rd_ready_i(fifo_ready)
	);

	qsm_rate_mon u_rate (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.frame_sync_i(frame_sync_i),
		.port_i(cfg_r.port),
		.tick_o(tick),
		.rate_err_o(rate_err_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Format decode

	assign slots = qsm_slots(cfg_r.port);
	assign shift = qsm_shift(cfg_r.mode);
	assign n_ch = slots >> shift;
	assign last_ph = 2'((3'h1 << shift) - 3'h1);

	// A frame tick waits here while the previous frame still drains
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			frame_pend_r <= 1'b0;
		end else if (tick) begin
			frame_pend_r <= 1'b1;
		end else if (start) begin
			frame_pend_r <= 1'b0;
		end
	end

	// Link frames start only on recovered ticks, never at sample rate
	assign start = (rd_state_r == QSM_RD_IDLE) && frame_pend_r;
	assign flush = start && (cfg_i != cfg_r);

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			cfg_r <= '{mode: QSM_SINGLE_RATE_MODE, port: QSM_PORT_MADI64};
			chan_count_r <= `QSM_SLOTS_MADI64;
		end else if (start) begin
			cfg_r <= cfg_i;
			chan_count_r <= qsm_slots(cfg_i.port) >> qsm_shift(cfg_i.mode);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Writer: high-rate samples into the fill bank

	assign fifo_ready = !fill_done_r && !flush;
	assign wr_fire = fifo_valid && fifo_ready;
	assign wr_last = (wr_ch_r == 6'(n_ch - 7'h01)) && (wr_ph_r == last_ph);
	// Channel c, period p lands in slot c*factor+p
	assign wr_addr = ({2'h0, wr_ch_r} << shift) | {6'h00, wr_ph_r};

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || flush) begin
			wr_ch_r <= 6'h00;
			wr_ph_r <= 2'h0;
		end else if (wr_fire) begin
			if (wr_ch_r == 6'(n_ch - 7'h01)) begin
				wr_ch_r <= 6'h00;
				if (wr_ph_r == last_ph) begin
					wr_ph_r <= 2'h0;
				end else begin
					wr_ph_r <= wr_ph_r + 2'h1;
				end
			end else begin
				wr_ch_r <= wr_ch_r + 6'h01;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (wr_fire) begin
			mem_r[{wr_bank_r, wr_addr[5:0]}] <= fifo_word.pcm;
		end
	end

	// Full bank holds off the writer, which backs up into the FIFO
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || flush) begin
			fill_done_r <= 1'b0;
		end else if (wr_fire && wr_last) begin
			fill_done_r <= 1'b1;
		end else if (start) begin
			fill_done_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			wr_bank_r <= 1'b0;
			rd_bank_r <= 1'b1;
			mute_r <= 1'b1;
		end else if (start) begin
			mute_r <= !fill_done_r || flush;
			if (fill_done_r && !flush) begin
				rd_bank_r <= wr_bank_r;
				wr_bank_r <= !wr_bank_r;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			underrun_r <= 1'b0;
		end else begin
			underrun_r <= start && (!fill_done_r || flush);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reader: one frame of slots per tick

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			rd_state_r <= QSM_RD_IDLE;
			rd_slot_r <= 7'h00;
		end else begin
			unique case (rd_state_r)
				QSM_RD_IDLE: begin
					if (start) begin
						rd_state_r <= QSM_RD_LOAD;
					end
				end
				QSM_RD_LOAD: begin
					rd_state_r <= QSM_RD_SEND;
					rd_slot_r <= 7'h00;
				end
				QSM_RD_SEND: begin
					if (link_ready_i) begin
						if (rd_slot_r == slots - 7'h01) begin
							rd_state_r <= QSM_RD_IDLE;
						end else begin
							rd_slot_r <= rd_slot_r + 7'h01;
						end
					end
				end
				default: begin
					rd_state_r <= QSM_RD_IDLE;
				end
			endcase
		end
	end

	assign load = (rd_state_r == QSM_RD_LOAD) ||
		((rd_state_r == QSM_RD_SEND) && link_ready_i &&
		(rd_slot_r != slots - 7'h01));
	assign nx_slot = (rd_state_r == QSM_RD_LOAD) ? 7'h00 : rd_slot_r + 7'h01;

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			link_word_r <= '0;
		end else if (load) begin
			link_word_r.frame_start <= (nx_slot == 7'h00);
			link_word_r.last <= (nx_slot == slots - 7'h01);
			link_word_r.mute <= mute_r;
			link_word_r.slot <= nx_slot[5:0];
			link_word_r.aud_ch <= 6'(nx_slot >> shift);
			link_word_r.phase <= nx_slot[1:0] & last_ph;
			link_word_r.pcm <= mute_r ? '0 : mem_r[{rd_bank_r, nx_slot[5:0]}];
		end
	end

	assign link_word_o = link_word_r;
	assign link_valid_o = (rd_state_r == QSM_RD_SEND);
	assign link_frame_o = (rd_state_r == QSM_RD_LOAD);
	assign chan_count_o = chan_count_r;
	assign underrun_o = underrun_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_load_quad64;
		rd_state_r == QSM_RD_LOAD && cfg_r.mode == QSM_QUAD_RATE_MODE &&
			cfg_r.port == QSM_PORT_MADI64;
	endsequence

	property p_quad_count;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_load_quad64 |-> chan_count_o == 7'h10;
	endproperty
	a_quad_count: assert property (p_quad_count) else $error("quad count");

	property p_double_count;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(link_frame_o && cfg_r.mode == QSM_DOUBLE_RATE_MODE &&
			cfg_r.port == QSM_PORT_MADI64) |-> chan_count_o == 7'h20;
	endproperty
	a_double_count: assert property (p_double_count) else $error("pairs");

	property p_opt_quad;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(link_frame_o && cfg_r.mode == QSM_QUAD_RATE_MODE &&
			cfg_r.port == QSM_PORT_OPTICAL) |-> chan_count_o == 7'h02;
	endproperty
	a_opt_quad: assert property (p_opt_quad) else $error("optical quad");

	property p_quad_map;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(link_valid_o && cfg_r.mode == QSM_QUAD_RATE_MODE) |->
			{link_word_o.aud_ch[3:0], link_word_o.phase} == link_word_o.slot;
	endproperty
	a_quad_map: assert property (p_quad_map) else $error("quad map");

	property p_phase_order;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(link_valid_o && link_ready_i && !link_word_o.last &&
			cfg_r.mode == QSM_QUAD_RATE_MODE) |=>
			link_word_o.phase == $past(link_word_o.phase) + 2'h1;
	endproperty
	a_phase_order: assert property (p_phase_order) else $error("order");

	property p_quad_last;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(link_valid_o && link_word_o.last &&
			cfg_r.mode == QSM_QUAD_RATE_MODE) |-> link_word_o.phase == 2'h3;
	endproperty
	a_quad_last: assert property (p_quad_last) else $error("quad group");

	property p_frame_begin;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		link_frame_o |=> link_valid_o && link_word_o.slot == 6'h00 &&
			link_word_o.frame_start;
	endproperty
	a_frame_begin: assert property (p_frame_begin) else $error("begin");

	sequence s_tick_idle;
		tick && rd_state_r == QSM_RD_IDLE && !frame_pend_r;
	endsequence

	property p_tick_frame;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_tick_idle |=> ##1 link_frame_o;
	endproperty
	a_tick_frame: assert property (p_tick_frame) else $error("tick frame");

	property p_opt_carrier;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(link_valid_o && link_word_o.last &&
			cfg_r.port == QSM_PORT_OPTICAL) |-> link_word_o.slot == 6'h07;
	endproperty
	a_opt_carrier: assert property (p_opt_carrier) else $error("carrier");
endmodule

/* File: qsm_mux_test.sv */
// Self-checking testbench of the quad-rate sample multiplexer
`timescale 1ns/1ps
module qsm_mux_test;
	import qsm_pkg::*;

	logic ref_clk_i;
	logic rstn_i;
	qsm_cfg_t cfg_i;
	logic frame_sync_i;
	qsm_in_t in_word_i;
	logic in_valid_i;
	logic in_ready_o;
	qsm_link_word_t link_word_o;
	logic link_valid_o;
	logic link_ready_i;
	logic link_frame_o;
	logic [6:0] chan_count_o;
	logic rate_err_o;
	logic underrun_o;
	logic slow;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	int t_rise = -100000;
	int frames_done = 0;
	int under_n = 0;
	int slot_n = 0;
	int e_slots = 64;
	int e_shift = 0;
	bit e_mute;
	qsm_cfg_t last_cfg = '0;
	logic [23:0] q[$];
	logic [23:0] bank [0:63];
	logic [15:0] seed = 16'h005A;
	qsm_link_word_t exp_w;

	qsm_mux dut (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i),
		.frame_sync_i(frame_sync_i), .in_word_i(in_word_i),
		.in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
		.link_word_o(link_word_o), .link_valid_o(link_valid_o),
		.link_ready_i(link_ready_i), .link_frame_o(link_frame_o),
		.chan_count_o(chan_count_o), .rate_err_o(rate_err_o),
		.underrun_o(underrun_o)
	);

	qsm_link_sink sink (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.link_valid_i(link_valid_o), .link_ready_o(link_ready_i),
		.slow_i(slow)
	);

	//////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) cyc <= cyc + 1;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int n_slots(input qsm_port_t p);
		if (p == QSM_PORT_MADI56) return 56;
		if (p == QSM_PORT_OPTICAL) return 8;
		return 64;
	endfunction

	function automatic logic rate_exp(input int p);
		if (cfg_i.port == QSM_PORT_MADI56) return p < 2315 || p > 2976;
		return p < 2579;
	endfunction

	task automatic wrap_up();
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp_word(input qsm_link_word_t got, input qsm_link_word_t e);
		checks_done++;
		if (got !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] e);
		checks_done++;
		if (got !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	//////////////////////////////////////////////////////////////////////
	// Reference model: stream words fill a bank in channel-major order
	always @(negedge ref_clk_i) begin
		if (rstn_i && link_frame_o) begin
			e_slots = n_slots(cfg_i.port);
			e_shift = cfg_i.mode == QSM_QUAD_RATE_MODE ? 2 :
				cfg_i.mode == QSM_DOUBLE_RATE_MODE ? 1 : 0;
			e_mute = cfg_i !== last_cfg || q.size() < e_slots;
			if (cfg_i !== last_cfg) q.delete();
			last_cfg = cfg_i;
			if (!e_mute)
				for (int k = 0; k < e_slots; k++)
					bank[(k % (e_slots >> e_shift)) * (1 << e_shift) +
						k / (e_slots >> e_shift)] = q.pop_front();
			slot_n = 0;
		end
		if (rstn_i && link_valid_o && link_ready_i) begin
			exp_w = '0;
			exp_w.frame_start = slot_n == 0;
			exp_w.last = slot_n == e_slots - 1;
			exp_w.mute = e_mute;
			exp_w.slot = 6'(slot_n);
			exp_w.aud_ch = 6'(slot_n >> e_shift);
			exp_w.phase = 2'(slot_n & ((1 << e_shift) - 1));
			exp_w.pcm = e_mute ? 24'h000000 : bank[slot_n];
			cmp_word(link_word_o, exp_w);
			slot_n++;
			if (slot_n == e_slots) frames_done++;
		end
		if (rstn_i && underrun_o) under_n++;
	end

	//////////////////////////////////////////////////////////////////////
	task automatic push_word(input logic [23:0] w);
		int n;
		logic rdy;
		n = 0;
		rdy = 1'b0;
		#1 in_word_i = '{pcm: w};
		in_valid_i = 1'b1;
		while (!rdy && n < 200) begin
			@(negedge ref_clk_i) rdy = in_ready_o;
			@(posedge ref_clk_i);
			n++;
		end
		if (!rdy) failures++;
		q.push_back(w);
	endtask

	task automatic fill(input int cnt);
		@(posedge ref_clk_i);
		repeat (cnt) begin
			seed = lfsr(seed);
			push_word({seed[7:0], seed});
		end
		#1 in_valid_i = 1'b0;
		repeat (6) @(posedge ref_clk_i);
	endtask

	task automatic set_cfg(input qsm_mode_t m, input qsm_port_t p, input logic s);
		@(posedge ref_clk_i);
		#1 cfg_i = '{mode: m, port: p};
		slow = s;
	endtask

	task automatic send_frame(input int period, input bit chk, input bit mute);
		int n;
		int fd;
		int un;
		while (cyc - t_rise < period) @(posedge ref_clk_i);
		#1 frame_sync_i = 1'b1;
		t_rise = cyc;
		fd = frames_done;
		un = under_n;
		repeat (8) @(posedge ref_clk_i);
		#1 frame_sync_i = 1'b0;
		n = 0;
		while (frames_done == fd && n < 1000) begin
			@(posedge ref_clk_i);
			n++;
		end
		repeat (4) @(posedge ref_clk_i);
		cmp_val(32'(frames_done - fd), 32'h1);
		cmp_val(32'(under_n - un), 32'(mute));
		cmp_val(32'(chan_count_o),
			32'(n_slots(cfg_i.port) >> e_shift));
		if (chk) cmp_val(32'(rate_err_o), 32'(rate_exp(period)));
	endtask

	//////////////////////////////////////////////////////////////////////
	initial begin
		rstn_i = 1'b0;
		cfg_i = '0;
		frame_sync_i = 1'b0;
		in_word_i = '0;
		in_valid_i = 1'b0;
		slow = 1'b0;
		repeat (8) @(posedge ref_clk_i);
		#1 rstn_i = 1'b1;
		@(posedge ref_clk_i);
		send_frame(2600, 0, 1);
		fill(64);
		send_frame(2600, 1, 0);
		set_cfg(QSM_DOUBLE_RATE_MODE, QSM_PORT_MADI64, 1'b1);
		send_frame(2600, 0, 1);
		fill(64);
		send_frame(2600, 1, 0);
		set_cfg(QSM_QUAD_RATE_MODE, QSM_PORT_MADI64, 1'b0);
		send_frame(2600, 0, 1);
		fill(68);
		@(negedge ref_clk_i) cmp_val(32'(in_ready_o), 32'h0);
		send_frame(2600, 1, 0);
		fill(60);
		send_frame(2400, 1, 0);
		set_cfg(QSM_QUAD_RATE_MODE, QSM_PORT_OPTICAL, 1'b1);
		send_frame(2600, 0, 1);
		fill(8);
		send_frame(2600, 1, 0);
		set_cfg(QSM_QUAD_RATE_MODE, QSM_PORT_MADI56, 1'b0);
		send_frame(2600, 0, 1);
		fill(55);
		send_frame(3000, 1, 1);
		fill(1);
		send_frame(2400, 1, 0);
		set_cfg(QSM_SINGLE_RATE_MODE, QSM_PORT_MADI56, 1'b1);
		send_frame(2600, 0, 1);
		fill(56);
		send_frame(2600, 1, 0);
		wrap_up();
	end

	// Hang guard: all frames need about 34000 cycles
	initial begin
		repeat (90000) @(posedge ref_clk_i);
		failures++;
		wrap_up();
	end
endmodule

/* File: qsm_pkg.sv */
// Types and decode functions of the quad-rate sample multiplexer
`include "qsm_defs.svh"
package qsm_pkg;

	typedef enum logic [1:0] {
		QSM_SINGLE_RATE_MODE = 2'b00,
		QSM_DOUBLE_RATE_MODE = 2'b01,
		QSM_QUAD_RATE_MODE = 2'b11
	} qsm_mode_t;

	typedef enum logic [1:0] {
		QSM_PORT_MADI64 = 2'b00,
		QSM_PORT_MADI56 = 2'b01,
		QSM_PORT_OPTICAL = 2'b11
	} qsm_port_t;

	typedef enum logic [1:0] {
		QSM_RD_IDLE = 2'b00,
		QSM_RD_LOAD = 2'b01,
		QSM_RD_SEND = 2'b11
	} qsm_rd_state_t;

	typedef struct packed {
		qsm_mode_t mode;
		qsm_port_t port;
	} qsm_cfg_t;

	typedef struct packed {
		logic [`QSM_PCM_W-1:0] pcm;
	} qsm_in_t;

	typedef struct packed {
		logic frame_start;
		logic last;
		logic mute;
		logic [5:0] slot;
		logic [5:0] aud_ch;
		logic [1:0] phase;
		logic [`QSM_PCM_W-1:0] pcm;
	} qsm_link_word_t;

	function automatic logic [6:0] qsm_slots(input qsm_port_t p);
		unique case (p)
			QSM_PORT_MADI56: return `QSM_SLOTS_MADI56;
			QSM_PORT_OPTICAL: return `QSM_SLOTS_OPTICAL;
			default: return `QSM_SLOTS_MADI64;
		endcase
	endfunction

	function automatic logic [1:0] qsm_shift(input qsm_mode_t m);
		unique case (m)
			QSM_QUAD_RATE_MODE: return 2'h2;
			QSM_DOUBLE_RATE_MODE: return 2'h1;
			default: return 2'h0;
		endcase
	endfunction

endpackage

/* File: qsm_rate_mon.sv */
// Frame tick from the recovered clock and frame-rate limit check
`timescale 1ns/1ps
`include "qsm_defs.svh"
module qsm_rate_mon (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Recovered frame clock and link format
	input wire logic frame_sync_i,
	input wire qsm_pkg::qsm_port_t port_i,
	// Results
	output logic tick_o,
	output logic rate_err_o
);
	import qsm_pkg::*;
	localparam logic [11:0] PAY64 = `QSM_PAY_MIN_CYC(64);
	localparam logic [11:0] PAY56 = `QSM_PAY_MIN_CYC(56);
	localparam logic [11:0] MIN64 =
		(`QSM_FS64_MIN_CYC > PAY64) ? `QSM_FS64_MIN_CYC : PAY64;
	localparam logic [11:0] MIN56 =
		(`QSM_FS56_MIN_CYC > PAY56) ? `QSM_FS56_MIN_CYC : PAY56;
	logic sync1_r, sync2_r, sync3_r;
	logic seen_r;
	logic [`QSM_PERIOD_W-1:0] period_r;
	logic [11:0] min_cyc;
	logic [11:0] max_cyc;

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= frame_sync_i;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	assign tick_o = sync2_r && !sync3_r;

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			period_r <= '0;
			seen_r <= 1'b0;
		end else if (tick_o) begin
			period_r <= 12'h001;
			seen_r <= 1'b1;
		end else if (period_r != `QSM_PERIOD_SAT) begin
			period_r <= period_r + 12'h001;
		end
	end

	// 64-slot and optical formats bound only the fastest rate
	always_comb begin
		min_cyc = MIN64;
		max_cyc = `QSM_PERIOD_SAT;
		if (port_i == QSM_PORT_MADI56) begin
			min_cyc = MIN56;
			max_cyc = `QSM_FS56_MAX_CYC;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			rate_err_o <= 1'b0;
		end else if (tick_o && seen_r) begin
			rate_err_o <= (period_r < min_cyc) || (period_r > max_cyc);
		end
	end

	property p_fast64;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(tick_o && seen_r && port_i == QSM_PORT_MADI64 &&
			period_r < `QSM_FS64_MIN_CYC) |=> rate_err_o;
	endproperty
	a_fast64: assert property (p_fast64) else $error("fast 64");

	property p_vari56;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(tick_o && seen_r && port_i == QSM_PORT_MADI56 &&
			period_r >= 12'h90B && period_r <= 12'hBA0) |=> !rate_err_o;
	endproperty
	a_vari56: assert property (p_vari56) else $error("56 band refused");

	property p_payload;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(tick_o && seen_r && port_i == QSM_PORT_MADI64 &&
			period_r < 12'hA00) |=> rate_err_o;
	endproperty
	a_payload: assert property (p_payload) else $error("payload over");
endmodule
